/* File: src/sovr_defines.vh */
// Purpose: constants for the synthesizer override, trim and hold-reset registers
// Assumes: 24-bit serial frames, one 20 MHz clock, synchronous reset
// Notes: offsets are register addresses on the serial port
//
// Function
// R1 - bit 7 picks strap pins or register values for synthesizer setup
// R2 - override off: enable, ref type, ref outputs follow the strap pins
// R3 - override on: enable, ref type, ref outputs follow register fields only
// R4 - second output mode bits 5:4: off, ref/1, ref/2, ref/4
// R5 - with override off both mode fields are ignored, straps decide outputs
// R6 - second output clocks only while first output also clocks
// R7 - first output mode bits 3:2: off, ref/1, ref/2, ref/4
// R8 - override on: bit 1 selects the single-ended reference input
// R9 - override on: bit 0 enables or disables the synthesizer
// R10 - host writes reserved bits as zero
// R11 - 7-bit trim sets oscillator frequency, loadable by calibration
// R12 - calibrated trim reads back, and may be written back later
// R13 - host leaves trim alone while calibration runs
// R14 - host sets hold-reset before changing synthesizer programming
// R15 - host clears hold-reset when programming is finished
// R16 - clearing hold-reset with calibration enabled starts calibration
// R17 - done flag reads 1 after calibration, or at once if disabled
// R18 - straps are synchronised before the override multiplexer
`ifndef SOVR_DEFINES_VH
`define SOVR_DEFINES_VH

`define SOVR_ADDR_W        15
`define SOVR_FRAME_BITS    5'd24
`define SOVR_HDR_LAST      5'd15
`define SOVR_DATA_LAST     5'd23

`define SOVR_ADDR_OVR      15'h0058
`define SOVR_ADDR_TRIM     15'h0059
`define SOVR_ADDR_HOLD     15'h005c
`define SOVR_ADDR_STAT     15'h005e

`define SOVR_OVR_SEL_BIT   7
`define SOVR_MODE2_HI      5
`define SOVR_MODE2_LO      4
`define SOVR_MODE1_HI      3
`define SOVR_MODE1_LO      2
`define SOVR_SE_BIT        1
`define SOVR_EN_BIT        0
`define SOVR_TRIM_HI       6
`define SOVR_HOLD_BIT      0
`define SOVR_DONE_BIT      0

`define SOVR_OVR_RST       8'h00
`define SOVR_TRIM_RST      7'h00
`define SOVR_HOLD_RST      1'b0
`define SOVR_MODE_OFF      2'h0

`endif

/* File: src/sovr_regs.v */
// Purpose: synthesizer strap override, oscillator trim and hold-reset registers
// Assumes: serial pins sampled as synchronous inputs, sclk far slower than sys_clk
// Notes: calibration engine and dividers sit outside; this block steers them
`include "sovr_defines.vh"

module sovr_regs (
  // clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // serial register port
  input  wire        spi_cs_n,
  input  wire        spi_sclk,
  input  wire        spi_sdi,
  output reg         spi_sdo,
  // strap pins
  input  wire        synth_enable_pin,
  input  wire        ref_type_pin,
  input  wire        clock_strap_low,
  input  wire        clock_strap_high,
  // calibration engine
  input  wire        oscillator_cal_enable,
  input  wire        cal_complete,
  input  wire        cal_trim_we,
  input  wire [6:0]  cal_trim_value,
  output reg         cal_start,
  // synthesizer controls
  output reg         synth_enable,
  output reg         single_ended_ref_input,
  output reg  [1:0]  first_refout_mode,
  output reg  [1:0]  second_refout_mode,
  output reg  [6:0]  oscillator_tune_code,
  output reg         synth_hold_reset
);

  // register storage
  reg [7:0]  synth_pin_override_r;
  reg        cal_done_r;

  // serial engine
  reg        sclk_d_r;
  reg [4:0]  bit_cnt_r;
  reg [22:0] shift_in_r;
  reg        rd_frame_r;
  reg [`SOVR_ADDR_W-1:0] addr_r;
  reg [7:0]  rd_shift_r;

  // strap synchronisers
  reg [3:0]  strap_meta_r;
  reg [3:0]  strap_sync_r;

  wire       sclk_rise;
  wire       sclk_fall;
  wire [23:0] frame_now;
  wire       hdr_done;
  wire       wr_done;
  wire [7:0] wr_data;
  wire       wr_ovr;
  wire       wr_trim;
  wire       wr_hold;
  wire       hold_release;
  wire       sdo_shift;
  wire       override_on;
  wire [1:0] strap_mode;
  reg        synth_enable_nxt;
  reg        single_ended_nxt;
  reg  [1:0] first_mode_nxt;
  reg  [1:0] second_mode_nxt;

  // reserved bit 6 of the override word always stores and reads as zero
  function [7:0] ovr_clean;
    input [7:0] data;
    begin
      ovr_clean = {data[`SOVR_OVR_SEL_BIT], 1'b0, data[`SOVR_MODE2_HI:0]};
    end
  endfunction

  // one address comparator shape for every write strobe
  function reg_hit;
    input [`SOVR_ADDR_W-1:0] addr;
    input [`SOVR_ADDR_W-1:0] target;
    begin
      reg_hit = (addr == target);
    end
  endfunction

  // second output only clocks while the first one clocks
  function [1:0] gate_second;
    input [1:0] first_mode;
    input [1:0] second_mode;
    begin
      if (first_mode == `SOVR_MODE_OFF)
        gate_second = `SOVR_MODE_OFF;
      else
        gate_second = second_mode;
    end
  endfunction

  // register read decode, used for header-time load
  function [7:0] read_word;
    input [`SOVR_ADDR_W-1:0] addr;
    input [7:0]              ovr;
    input [6:0]              trim;
    input                    hold;
    input                    done;
    begin
      case (addr)
        `SOVR_ADDR_OVR:  read_word = ovr_clean(ovr);
        `SOVR_ADDR_TRIM: read_word = {1'b0, trim};
        `SOVR_ADDR_HOLD: read_word = {7'h00, hold};
        `SOVR_ADDR_STAT: read_word = {7'h00, done};
        default:         read_word = 8'h00;
      endcase
    end
  endfunction

  // one edge detector serves both serial edges
  assign sclk_rise = ~spi_cs_n & spi_sclk & ~sclk_d_r;
  assign sclk_fall = ~spi_cs_n & ~spi_sclk & sclk_d_r;
  assign frame_now = {shift_in_r, spi_sdi};
  assign hdr_done  = sclk_rise & (bit_cnt_r == `SOVR_HDR_LAST);
  assign wr_done   = sclk_rise & (bit_cnt_r == `SOVR_DATA_LAST) & ~rd_frame_r;
  assign wr_data   = frame_now[7:0];
  // frame layout: read flag, 15-bit address, data byte, msb first
  assign wr_ovr    = wr_done & reg_hit(addr_r, `SOVR_ADDR_OVR);
  assign wr_trim   = wr_done & reg_hit(addr_r, `SOVR_ADDR_TRIM);
  assign wr_hold   = wr_done & reg_hit(addr_r, `SOVR_ADDR_HOLD);
  // data leaves on falling edges so it is stable at the next rise
  assign sdo_shift = sclk_fall & rd_frame_r & (bit_cnt_r > `SOVR_HDR_LAST);

  // R16 start on release
  assign hold_release = wr_hold & synth_hold_reset & ~wr_data[`SOVR_HOLD_BIT];

  // edge history runs while deselected so a frame never starts on a stale level
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= spi_sclk;
    end
  end

  // count saturates at a full frame, so trailing bits are ignored
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      bit_cnt_r <= 5'd0;
    end else if (spi_cs_n) begin
      // deselect aborts any partial frame
      bit_cnt_r <= 5'd0;
    end else if (sclk_rise && (bit_cnt_r != `SOVR_FRAME_BITS)) begin
      bit_cnt_r <= bit_cnt_r + 5'd1;
    end
  end

  // last 23 bits kept; with the live data pin that is a full frame
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_in_r <= 23'h000000;
    end else if (sclk_rise) begin
      shift_in_r <= frame_now[22:0];
    end
  end

  // header capture and read-back shifter; rise and fall never coincide
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_frame_r <= 1'b0;
      addr_r     <= {`SOVR_ADDR_W{1'b0}};
      rd_shift_r <= 8'h00;
      spi_sdo    <= 1'b0;
    end else if (spi_cs_n) begin
      rd_frame_r <= 1'b0;
    end else if (hdr_done) begin
      rd_frame_r <= frame_now[15];
      addr_r     <= frame_now[`SOVR_ADDR_W-1:0];
      rd_shift_r <= read_word(frame_now[`SOVR_ADDR_W-1:0], synth_pin_override_r,
                              oscillator_tune_code, synth_hold_reset,
                              cal_done_r | ~oscillator_cal_enable);
    end else if (sdo_shift) begin
      spi_sdo    <= rd_shift_r[7];
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end
  end

  // R10 reserved bit dropped
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      synth_pin_override_r <= `SOVR_OVR_RST;
    end else if (wr_ovr) begin
      synth_pin_override_r <= ovr_clean(wr_data);
    end
  end

  // R14 hold-reset set
  // R15 hold-reset clear
  // hold-reset brackets divider, bias and calibration programming
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      synth_hold_reset <= `SOVR_HOLD_RST;
    end else if (wr_hold) begin
      synth_hold_reset <= wr_data[`SOVR_HOLD_BIT];
    end
  end

  // R11 trim load
  // R12 calibrated trim retained
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      oscillator_tune_code <= `SOVR_TRIM_RST;
    end else if (cal_trim_we) begin
      // engine wins: a host write mid-calibration is a host fault anyway
      oscillator_tune_code <= cal_trim_value;
    end else if (wr_trim) begin
      // R12 host restore path
      oscillator_tune_code <= wr_data[`SOVR_TRIM_HI:0];
    end
  end

  // R16 calibration kick
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cal_start <= 1'b0;
    end else begin
      cal_start <= hold_release & oscillator_cal_enable;
    end
  end

  // R17 done flag
  // status reads done or disabled, so a skipped calibration shows ready
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cal_done_r <= 1'b0;
    end else if (cal_complete) begin
      // completion wins over the clear in the same cycle
      cal_done_r <= 1'b1;
    end else if (hold_release | (wr_hold & wr_data[`SOVR_HOLD_BIT])) begin
      cal_done_r <= 1'b0;
    end
  end

  // R18 strap synchroniser
  // only the second stage is read; the first may go metastable
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      strap_meta_r <= 4'h0;
      strap_sync_r <= 4'h0;
    end else begin
      strap_meta_r <= {clock_strap_high, clock_strap_low, ref_type_pin, synth_enable_pin};
      strap_sync_r <= strap_meta_r;
    end
  end

  // R1 mode select
  assign override_on = synth_pin_override_r[`SOVR_OVR_SEL_BIT];
  // both outputs share the two-bit strap code in pin mode
  assign strap_mode  = strap_sync_r[3:2];

  always @* begin
    if (override_on) begin
      // R3 register mode
      // R9 enable value
      synth_enable_nxt = synth_pin_override_r[`SOVR_EN_BIT];
      // R8 single-ended select
      single_ended_nxt = synth_pin_override_r[`SOVR_SE_BIT];
      // R7 first output mode
      first_mode_nxt   = synth_pin_override_r[`SOVR_MODE1_HI:`SOVR_MODE1_LO];
      // R4 second output mode
      // R6 second needs first
      second_mode_nxt  = gate_second(first_mode_nxt,
                                     synth_pin_override_r[`SOVR_MODE2_HI:`SOVR_MODE2_LO]);
    end else begin
      // R2 pin mode
      // R5 fields ignored
      synth_enable_nxt = strap_sync_r[0];
      single_ended_nxt = strap_sync_r[1];
      first_mode_nxt   = strap_mode;
      // R6 second needs first
      second_mode_nxt  = gate_second(strap_mode, strap_mode);
    end
  end

  // registered so a change of override select cannot glitch the controls
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      synth_enable           <= 1'b0;
      single_ended_ref_input <= 1'b0;
    end else begin
      synth_enable           <= synth_enable_nxt;
      single_ended_ref_input <= single_ended_nxt;
    end
  end

  // both modes update on one edge, so the second never leads the first
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      first_refout_mode  <= `SOVR_MODE_OFF;
      second_refout_mode <= `SOVR_MODE_OFF;
    end else begin
      first_refout_mode  <= first_mode_nxt;
      second_refout_mode <= second_mode_nxt;
    end
  end

endmodule // sovr_regs

/* File: tb/sovr_monitor.sv */
// Purpose: port assertions for sovr_regs
// Assumes: one clock, sync reset
// Notes: registers seen by effect only
module sovr_monitor (
  // clock
  input logic       sys_clk,
  input logic       sys_rst,
  // inputs
  input logic       spi_cs_n,
  input logic       oscillator_cal_enable,
  input logic       cal_trim_we,
  input logic [6:0] cal_trim_value,
  // outputs
  input logic       cal_start,
  input logic [1:0] first_refout_mode,
  input logic [1:0] second_refout_mode,
  input logic [6:0] oscillator_tune_code,
  input logic       synth_hold_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_gate; first_refout_mode == 2'h0 |-> second_refout_mode == 2'h0; endproperty
  a_gate: assert property (p_gate) else $error("second out on");
  property p_go; $fell(synth_hold_reset) && $past(oscillator_cal_enable) |-> cal_start; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_pulse; cal_start |=> !cal_start; endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  property p_cause; cal_start |-> $fell(synth_hold_reset) && $past(oscillator_cal_enable); endproperty
  a_cause: assert property (p_cause) else $error("stray start");
  property p_load; cal_trim_we |=> oscillator_tune_code == $past(cal_trim_value); endproperty
  a_load: assert property (p_load) else $error("trim not loaded");
  property p_keep; !cal_trim_we && spi_cs_n |=> $stable(oscillator_tune_code); endproperty
  a_keep: assert property (p_keep) else $error("trim moved");
  property p_hold; spi_cs_n [*2] |-> $stable(synth_hold_reset); endproperty
  a_hold: assert property (p_hold) else $error("hold moved");
  property p_set; $rose(synth_hold_reset) |-> !$past(spi_cs_n) && !cal_start; endproperty
  a_set: assert property (p_set) else $error("bad hold set");
  c_go: cover property (cal_start);
  c_load: cover property (cal_trim_we);
  c_div4: cover property (second_refout_mode == 2'h3);
endmodule // sovr_monitor

/* File: tb/sovr_host.sv */
// Purpose: serial host model for register frames
// Assumes: four system clocks per sclk phase
// Notes: data line inverts once deselected
module sovr_host (
  // clock
  input  logic sys_clk,
  // serial port
  input  logic spi_sdo,
  output logic spi_cs_n = 1'h1,
  output logic spi_sclk = 1'h0,
  output logic spi_sdi  = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // caller frames keep reserved bits zero
  task automatic xfer(input logic [23:0] f, output logic [7:0] q);
    q = 8'h00;
    spi_cs_n = 1'h0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = f[i];
      spi_sclk = 1'h0;
      tick(4);
      if (i < 8) q[i] = spi_sdo;
      spi_sclk = 1'h1;
      tick(4);
    end
    spi_cs_n = 1'h1;
    spi_sdi = ~spi_sdi;
    tick(2);
  endtask
endmodule // sovr_host

/* File: tb/tb_top.sv */
// Purpose: directed frames and pin stimulus for sovr_regs
// Assumes: host model paces the serial clock
// Notes: trim left alone while calibration runs
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, sys_rst = 1'h1, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, cal_start;
  logic synth_enable_pin = 1'h0, ref_type_pin = 1'h0, clock_strap_low = 1'h0;
  logic clock_strap_high = 1'h0, oscillator_cal_enable = 1'h0, cal_complete = 1'h0;
  logic cal_trim_we = 1'h0, synth_enable, single_ended_ref_input, synth_hold_reset;
  logic [6:0] cal_trim_value = 7'h00, oscillator_tune_code;
  logic [1:0] first_refout_mode, second_refout_mode;
  logic [7:0] q;
  int n_errors = 0, n_compared = 0, n_starts = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cal_start === 1'h1) n_starts <= n_starts + 1;
  sovr_regs dut (.sys_clk, .sys_rst, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .synth_enable_pin,
    .ref_type_pin, .clock_strap_low, .clock_strap_high, .oscillator_cal_enable, .cal_complete,
    .cal_trim_we, .cal_trim_value, .cal_start, .synth_enable, .single_ended_ref_input,
    .first_refout_mode, .second_refout_mode, .oscillator_tune_code, .synth_hold_reset);
  sovr_host host (.sys_clk, .spi_sdo, .spi_cs_n, .spi_sclk, .spi_sdi);
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // reads compare against d, writes send it
  task automatic rw(input logic r, input logic [7:0] a, input logic [7:0] d);
    host.xfer({r, 7'h00, a, r ? 8'h00 : d}, q);
    if (r) chk("reg", d, q);
  endtask
  task automatic ctl(input logic [5:0] e);
    chk("controls", {2'h0, e}, {2'h0, synth_enable, single_ended_ref_input,
      first_refout_mode, second_refout_mode});
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1500000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 sys_rst = 1'h0;
    ctl(6'h00);
    rw(1, 8'h58, 8'h00);
    rw(1, 8'h59, 8'h00);
    rw(1, 8'h5c, 8'h00);
    rw(1, 8'h5a, 8'h00);
    rw(0, 8'h58, 8'h3f);
    for (int s = 0; s < 16; s++) begin
      {synth_enable_pin, ref_type_pin, clock_strap_high, clock_strap_low} = s[3:0];
      repeat (4) @(posedge sys_clk);
      #1 ctl({s[3:0], s[1:0]});
    end
    $display("straps done");
    for (int i = 0; i < 4; i++) begin
      rw(0, 8'h58, {2'b10, ~i[1:0], i[1:0], i[1:0]});
      ctl({i[0], i[1], i[1:0], i[1:0] == 2'h0 ? 2'h0 : ~i[1:0]});
      rw(1, 8'h58, {2'b10, ~i[1:0], i[1:0], i[1:0]});
    end
    rw(0, 8'h58, 8'hb4);
    ctl(6'h07);
    rw(0, 8'h58, 8'h00);
    ctl(6'h3f);
    $display("override done");
    rw(0, 8'h59, 8'h55);
    chk("tune", 8'h55, {1'h0, oscillator_tune_code});
    cal_trim_value = 7'h2a;
    cal_trim_we = 1'h1;
    @(posedge sys_clk) #1 cal_trim_we = 1'h0;
    rw(1, 8'h59, 8'h2a);
    $display("trim done");
    oscillator_cal_enable = 1'h1;
    rw(0, 8'h5c, 8'h01);
    chk("hold", 8'h01, {7'h00, synth_hold_reset});
    rw(1, 8'h5e, 8'h00);
    rw(0, 8'h5c, 8'h00);
    chk("hold", 8'h00, {7'h00, synth_hold_reset});
    chk("starts", 8'h01, n_starts[7:0]);
    cal_complete = 1'h1;
    @(posedge sys_clk) #1 cal_complete = 1'h0;
    rw(1, 8'h5e, 8'h01);
    oscillator_cal_enable = 1'h0;
    rw(0, 8'h5c, 8'h01);
    rw(0, 8'h5c, 8'h00);
    rw(1, 8'h5e, 8'h01);
    chk("starts", 8'h01, n_starts[7:0]);
    $display("hold done");
    final_report();
  end
endmodule // tb_top
bind sovr_regs sovr_monitor mon (.sys_clk, .sys_rst, .spi_cs_n, .oscillator_cal_enable,
  .cal_trim_we, .cal_trim_value, .cal_start, .first_refout_mode, .second_refout_mode,
  .oscillator_tune_code, .synth_hold_reset);
